// ===== logic/jdr_chains.sv
// data chains behind a test access port, with instruction register
// assumes a TAP state machine on clk giving state levels; link pins async
// How it works
// - six chains, instruction picks one to TDO
// - identification chain 32 bits, LSB reads 1
// - identification capture loads fixed identity value
// - bypass is one stage capturing 0
// - per pad cells: input, output, output enable
// - chain starts at pad nearest port
// - sample captures pad values on Capture-DR
// - Shift-DR shifts samples out, preload in
// - hold data drives pads or core inputs
// - three debug chains of 35 bits
// - four-bit instruction decode table
// - unlisted codes act as bypass
// - resets load identification instruction
// - Update-DR copies chain into hold registers
`timescale 1ns/1ps
`include "jdr_consts.svh"
module jdr_chains
	import jdr_pkg::*;
#(
	parameter logic [`JDR_ID_W-1:0] IDENT_VALUE = 32'h0ABC_D001 // arbitrary value
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     tck,
	input  wire logic                     tdi,
	input  wire logic                     trst_n,
	output logic                          tdo,
	output logic                          tdoOe_n,
	input  wire logic                     tapReset,
	input  wire logic                     captureIr,
	input  wire logic                     shiftIr,
	input  wire logic                     updateIr,
	input  wire logic                     captureDr,
	input  wire logic                     shiftDr,
	input  wire logic                     updateDr,
	input  wire logic [`JDR_NUM_PADS-1:0] padIn,
	input  wire logic [`JDR_NUM_PADS-1:0] coreOut,
	input  wire logic [`JDR_NUM_PADS-1:0] coreOe_n,
	output logic      [`JDR_NUM_PADS-1:0] padOut,
	output logic      [`JDR_NUM_PADS-1:0] padOe_n,
	output logic      [`JDR_NUM_PADS-1:0] coreIn,
	output logic      [`JDR_IR_W-1:0]     irCurrent,
	input  wire logic [`JDR_DAP_W-1:0]    dapCaptureData,
	output logic      [`JDR_DAP_W-1:0]    dapUpdateData,
	output logic      [2:0]               dapSelect,
	output logic                          dapCapture,
	output logic                          dapUpdate
);
	logic [`JDR_SYNC_W-1:0]   syncVec;
	logic                     tckRise;
	logic                     tckFall;
	logic                     tdiS;
	logic                     trstS_n;
	logic [`JDR_NUM_PADS-1:0] padInS;
	logic [`JDR_IR_W-1:0]     irShift;
	jdr_chain_t               chain;
	logic [`JDR_ID_W-1:0]     idShift;
	logic                     bypShift;
	logic [`JDR_BSR_LEN-1:0]  bsrShift;
	logic [`JDR_BSR_LEN-1:0]  bsrHold;
	logic [`JDR_DAP_W-1:0]    dapShift;
	logic [`JDR_BSR_LEN-1:0]  bsrSample;
	logic                     capEv;
	logic                     shiftEv;
	logic                     updEv;
	logic                     isDap;
	logic                     next_tdo;

	// ************************************
	// pin synchronisation
	// ************************************
	jdr_pin_sync #(.W(`JDR_SYNC_W)) uSync (
		.clk     (clk),
		.rst_n   (rst_n),
		.pinIn   ({padIn, trst_n, tdi, tck}),
		.pinSync (syncVec),
		.rise    (tckRise),
		.fall    (tckFall)
	);
	assign tdiS    = syncVec[1];
	assign trstS_n = syncVec[2];
	assign padInS  = syncVec[`JDR_SYNC_W-1:3];

	assign capEv   = tckRise & captureDr;
	assign shiftEv = tckRise & shiftDr;
	assign updEv   = tckFall & updateDr;

	// ************************************
	// instruction register
	// ************************************
	always_ff @(posedge clk) begin
		if (!rst_n || !trstS_n || tapReset) begin
			irShift   <= `JDR_IR_IDENT;
			irCurrent <= `JDR_IR_IDENT;
		end else begin
			if (tckRise && captureIr)
				irShift <= `JDR_IR_CAPTURE;
			else if (tckRise && shiftIr)
				irShift <= {tdiS, irShift[`JDR_IR_W-1:1]};
			if (tckFall && updateIr)
				irCurrent <= irShift;
		end
	end

	// decode, unlisted codes fall to bypass
	always_comb begin
		case (irCurrent)
			`JDR_IR_EXTEST, `JDR_IR_INTEST, `JDR_IR_SAMPLE: chain = CH_BSR;
			`JDR_IR_CANCEL: chain = CH_CANCEL;
			`JDR_IR_DPORT:  chain = CH_DPORT;
			`JDR_IR_APORT:  chain = CH_APORT;
			`JDR_IR_IDENT:  chain = CH_IDENT;
			default:        chain = CH_BYPASS;
		endcase
	end
	assign isDap = (chain == CH_APORT) || (chain == CH_DPORT) || (chain == CH_CANCEL);

	// ************************************
	// identification and bypass chains
	// ************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			idShift <= '0;
		end else if (chain == CH_IDENT) begin
			if (capEv)
				idShift <= {IDENT_VALUE[`JDR_ID_W-1:1], 1'b1};
			else if (shiftEv)
				idShift <= {tdiS, idShift[`JDR_ID_W-1:1]};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			bypShift <= 1'b0;
		else if (chain == CH_BYPASS && capEv)
			bypShift <= 1'b0;
		else if (chain == CH_BYPASS && shiftEv)
			bypShift <= tdiS;
	end

	// ************************************
	// boundary chain, pad 0 nearest the port
	// ************************************
	genvar p;
	generate
		for (p = 0; p < `JDR_NUM_PADS; p++) begin : gPad
			assign bsrSample[`JDR_CELLS*p+`JDR_CELL_IN]  = padInS[p];
			assign bsrSample[`JDR_CELLS*p+`JDR_CELL_OUT] = padOut[p];
			assign bsrSample[`JDR_CELLS*p+`JDR_CELL_OE]  = padOe_n[p];

			always_ff @(posedge clk) begin
				if (!rst_n) begin
					padOut[p]  <= 1'b0;
					padOe_n[p] <= 1'b1;
					coreIn[p]  <= 1'b0;
				end else begin
					if (irCurrent == `JDR_IR_EXTEST) begin
						padOut[p]  <= bsrHold[`JDR_CELLS*p+`JDR_CELL_OUT];
						padOe_n[p] <= bsrHold[`JDR_CELLS*p+`JDR_CELL_OE];
					end else begin
						padOut[p]  <= coreOut[p];
						padOe_n[p] <= coreOe_n[p];
					end
					if (irCurrent == `JDR_IR_INTEST)
						coreIn[p] <= bsrHold[`JDR_CELLS*p+`JDR_CELL_IN];
					else
						coreIn[p] <= padInS[p];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bsrShift <= '0;
			bsrHold  <= '0;
		end else if (chain == CH_BSR) begin
			if (capEv)
				bsrShift <= bsrSample;
			else if (shiftEv)
				bsrShift <= {tdiS, bsrShift[`JDR_BSR_LEN-1:1]};
			if (updEv)
				bsrHold <= bsrShift;
		end
	end

	// ************************************
	// debug access chains, shared shifter
	// ************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dapShift      <= '0;
			dapUpdateData <= '0;
			dapUpdate     <= 1'b0;
		end else begin
			dapUpdate <= 1'b0;
			if (isDap && capEv)
				dapShift <= dapCaptureData;
			else if (isDap && shiftEv)
				dapShift <= {tdiS, dapShift[`JDR_DAP_W-1:1]};
			if (isDap && updEv) begin
				dapUpdateData <= dapShift;
				dapUpdate     <= 1'b1;
			end
		end
	end
	assign dapSelect  = {chain == CH_CANCEL, chain == CH_DPORT, chain == CH_APORT};
	assign dapCapture = isDap & capEv;

	// ************************************
	// serial output, changes on falling tck
	// ************************************
	always_comb begin
		case (chain)
			CH_IDENT:  next_tdo = idShift[0];
			CH_BYPASS: next_tdo = bypShift;
			CH_BSR:    next_tdo = bsrShift[0];
			default:   next_tdo = dapShift[0];
		endcase
		if (shiftIr)
			next_tdo = irShift[0];
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tdo     <= 1'b0;
			tdoOe_n <= 1'b1;
		end else if (tckFall) begin
			tdo     <= next_tdo;
			tdoOe_n <= ~(shiftDr | shiftIr);
		end
	end

	// ************************************
	// checks
	// ************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_ir_reset_ident: assert property (!trstS_n |=> irCurrent == `JDR_IR_IDENT)
		else $error("instruction not identification after test reset");
	a_id_capture: assert property (chain == CH_IDENT && capEv |=>
		idShift[0] == 1'b1 && idShift[`JDR_ID_W-1:1] == IDENT_VALUE[`JDR_ID_W-1:1])
		else $error("identity capture wrong");
	a_bypass_zero: assert property (chain == CH_BYPASS && capEv |=> !bypShift)
		else $error("bypass did not capture zero");
	a_unlisted_bypass: assert property (irCurrent[3:2] == 2'b01 |-> chain == CH_BYPASS)
		else $error("unlisted code not bypass");
	a_bsr_sample: assert property (chain == CH_BSR && capEv
		|=> bsrShift[`JDR_CELL_IN] == $past(padInS[0])
		&& bsrShift[`JDR_CELL_OE] == $past(padOe_n[0]))
		else $error("boundary sample wrong");
	a_bsr_shift: assert property (chain == CH_BSR && shiftEv && !capEv
		|=> bsrShift[`JDR_BSR_LEN-1] == $past(tdiS))
		else $error("boundary shift-in wrong");
	a_bsr_update: assert property (chain == CH_BSR && updEv |=> bsrHold == $past(bsrShift))
		else $error("hold not updated");
	a_extest_drive: assert property (irCurrent == `JDR_IR_EXTEST [*2]
		|-> padOut[0] == $past(bsrHold[`JDR_CELL_OUT]))
		else $error("extest pad not driven from hold");
	a_dap_strobe: assert property (isDap && updEv |=> dapUpdate ##1 !dapUpdate)
		else $error("debug update strobe wrong");
	a_dap_capture: assert property (dapCapture |=> dapShift == $past(dapCaptureData))
		else $error("debug capture wrong");

	c_ident_shift: cover property (chain == CH_IDENT && capEv ##[1:300] shiftEv);
	c_extest_update: cover property (irCurrent == `JDR_IR_EXTEST && updEv);
	c_dap_update: cover property (dapUpdate && dapSelect == 3'h4);
endmodule

// ===== inc/jdr_consts.svh
// constants of the test-port data chains
// assumes inclusion by the package and the design modules
`ifndef JDR_CONSTS_SVH
`define JDR_CONSTS_SVH

// ************************************
// instruction codes
// ************************************
`define JDR_IR_W        4
`define JDR_IR_EXTEST   4'h0
`define JDR_IR_INTEST   4'h1
`define JDR_IR_SAMPLE   4'h2
`define JDR_IR_CANCEL   4'h8
`define JDR_IR_DPORT    4'hA
`define JDR_IR_APORT    4'hB
`define JDR_IR_IDENT    4'hE
`define JDR_IR_BYPASS   4'hF
`define JDR_IR_CAPTURE  4'h1

// ************************************
// chain layout
// ************************************
`define JDR_ID_W        32
`define JDR_NUM_PADS    8
`define JDR_CELLS       3
`define JDR_BSR_LEN     24
`define JDR_CELL_IN     0
`define JDR_CELL_OUT    1
`define JDR_CELL_OE     2
`define JDR_DAP_W       35
`define JDR_SYNC_W      11

`endif

// ===== inc/jdr_pkg.sv
// types of the test-port data chains
// assumes jdr_consts.svh on the include path
package jdr_pkg;
	`include "jdr_consts.svh"

	typedef enum logic [5:0] {
		CH_IDENT  = 6'h01,
		CH_BYPASS = 6'h02,
		CH_BSR    = 6'h04,
		CH_APORT  = 6'h08,
		CH_DPORT  = 6'h10,
		CH_CANCEL = 6'h20
	} jdr_chain_t;
endpackage

// ===== logic/jdr_pin_sync.sv
// two-stage synchroniser for link pins, edge finder on bit 0
// assumes async inputs, one system clock
`timescale 1ns/1ps
module jdr_pin_sync
	import jdr_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinSync,
	output logic              rise,
	output logic              fall
);
	logic [W-1:0] stage1;
	logic         prev0;
	logic [2:0]   warm;

	// ************************************
	// two flops, then edge history
	// ************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stage1  <= '0;
			pinSync <= '0;
			prev0   <= 1'b0;
			warm    <= '0;
		end else begin
			stage1  <= pinIn;
			pinSync <= stage1;
			prev0   <= pinSync[0];
			warm    <= {warm[1:0], 1'b1};
		end
	end

	// edges masked until history holds real samples, no false edge after reset
	assign rise = warm[2] & pinSync[0] & ~prev0;
	assign fall = warm[2] & ~pinSync[0] & prev0;
endmodule

// ===== bench/jdr_probe.sv
// probe host model: makes the link clock, serial data and TAP state levels
// assumes clk at 40 MHz; tck half period of 4 clk, idle high
`timescale 1ns/1ps
module jdr_probe (
	input  wire logic       clk,
	input  wire logic       tdo,
	output logic            tck,
	output logic            tdi,
	output logic      [6:0] st
);
	// st: {reset, capIr, shIr, updIr, capDr, shDr, updDr}
	logic testModePin0 = 1'h0;
	logic testModePin1 = 1'h0;
	initial begin
		tck = 1'h1;
		tdi = 1'h0;
		st  = 7'h00;
	end
	// q returns tdo as left by the previous fall
	task automatic step(input logic [6:0] s, input logic d, output logic q);
		q = tdo;
		tck <= 1'h0;
		st  <= s;
		tdi <= (s[1] | s[4]) ? d : ~tdi;
		repeat (4) @(posedge clk);
		tck <= 1'h1;
		repeat (4) @(posedge clk);
	endtask
	// capture, len shifts lsb first, update, idle
	task automatic scan(input logic ir, input int len, input logic [63:0] din,
			output logic [63:0] dout);
		logic q;
		dout = 64'h0;
		step(ir ? 7'h20 : 7'h04, 1'h0, q);
		for (int i = 0; i < len; i++) begin
			step(ir ? 7'h10 : 7'h02, din[i], q);
			if (i > 0)
				dout[i-1] = q;
		end
		step(ir ? 7'h08 : 7'h01, 1'h0, q);
		dout[len-1] = q;
		step(7'h00, 1'h0, q);
	endtask
endmodule

// ===== bench/jdr_chains_tb.sv
// self-checking bench of the test-port data chains
// assumes jdr_probe as the host; checks results with its own check task
`timescale 1ns/1ps
module jdr_chains_tb;
	import jdr_pkg::*;
	localparam logic [31:0] IDV = 32'h1234_5670; // arbitrary value
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        trst_n = 1'h1;
	logic        tck, tdi, tdo, tdoOe_n, dapCapture, dapUpdate, q;
	logic [6:0]  st;
	logic [7:0]  padIn = 8'h00, coreOut = 8'h00, coreOe_n = 8'hFF;
	logic [7:0]  padOut, padOe_n, coreIn;
	logic [3:0]  irCurrent;
	logic [34:0] dapCaptureData = 35'h0, dapUpdateData;
	logic [2:0]  dapSelect;
	logic [63:0] dout;
	int          err_count = 0, num_checks = 0, capCount = 0, updCount = 0;

	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		capCount <= capCount + int'(dapCapture);
		updCount <= updCount + int'(dapUpdate);
	end

	jdr_probe i_probe (.clk(clk), .tdo(tdo), .tck(tck), .tdi(tdi), .st(st));
	jdr_chains #(.IDENT_VALUE(IDV)) i_dut (
		.clk(clk), .rst_n(rst_n), .tck(tck), .tdi(tdi), .trst_n(trst_n),
		.tdo(tdo), .tdoOe_n(tdoOe_n), .tapReset(st[6]), .captureIr(st[5]),
		.shiftIr(st[4]), .updateIr(st[3]), .captureDr(st[2]), .shiftDr(st[1]),
		.updateDr(st[0]), .padIn(padIn), .coreOut(coreOut), .coreOe_n(coreOe_n),
		.padOut(padOut), .padOe_n(padOe_n), .coreIn(coreIn), .irCurrent(irCurrent),
		.dapCaptureData(dapCaptureData), .dapUpdateData(dapUpdateData),
		.dapSelect(dapSelect), .dapCapture(dapCapture), .dapUpdate(dapUpdate));

	task automatic check(input logic [63:0] got, exp, input string what);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	function automatic logic [23:0] bsr(input logic [7:0] i, o, e);
		for (int p = 0; p < 8; p++)
			bsr[3*p +: 3] = {e[p], o[p], i[p]};
	endfunction
	task automatic load_ir(input logic [3:0] c);
		i_probe.scan(1'h1, 4, {60'h0, c}, dout);
		check(irCurrent, c, "instruction");
	endtask

	task automatic t_ident;
		check(irCurrent, 4'hE, "reset instruction");
		check(tdoOe_n, 1'h1, "tdo idle");
		i_probe.scan(1'h0, 32, 64'h0, dout);
		check(dout[31:0], IDV | 32'h1, "identity");
		i_probe.step(7'h04, 1'h0, q);
		i_probe.step(7'h02, 1'h0, q);
		check(tdoOe_n, 1'h0, "tdo driven");
		i_probe.step(7'h01, 1'h0, q);
		i_probe.step(7'h00, 1'h0, q);
		check(tdoOe_n, 1'h1, "tdo released");
	endtask
	task automatic t_bypass;
		logic [3:0] codes [9] = '{4'hF, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hC, 4'hD};
		foreach (codes[k]) begin
			load_ir(codes[k]);
			i_probe.scan(1'h0, 8, 64'hA5, dout);
			check(dout[7:0], 8'h4A, "bypass path");
			check(dapSelect, 3'h0, "no debug chain");
		end
	endtask
	task automatic t_dap;
		logic [3:0] codes [3] = '{4'h8, 4'hA, 4'hB};
		logic [2:0] sel [3] = '{3'h4, 3'h2, 3'h1};
		logic [34:0] din;
		int c0, u0;
		foreach (codes[k]) begin
			dapCaptureData <= 35'h5_1234_5678 ^ codes[k];
			din = 35'h2_ABCD_0123 ^ {codes[k], 8'h00};
			load_ir(codes[k]);
			check(dapSelect, sel[k], "debug select");
			c0 = capCount;
			u0 = updCount;
			i_probe.scan(1'h0, 35, din, dout);
			check(dout[34:0], dapCaptureData, "debug capture");
			check(dapUpdateData, din, "debug update");
			check(capCount - c0, 1, "capture strobes");
			check(updCount - u0, 1, "update strobes");
		end
	endtask
	task automatic t_bsr;
		padIn <= 8'h3C;
		coreOut <= 8'hA5;
		coreOe_n <= 8'h0F;
		load_ir(4'h2);
		check(coreIn, 8'h3C, "core in normal");
		check(padOut, 8'hA5, "pad out normal");
		i_probe.scan(1'h0, 24, bsr(8'h96, 8'h5A, 8'hC3), dout);
		check(dout[23:0], bsr(8'h3C, 8'hA5, 8'h0F), "sample");
		load_ir(4'h0);
		check(padOut, 8'h5A, "extest out");
		check(padOe_n, 8'hC3, "extest oe");
		load_ir(4'h1);
		check(coreIn, 8'h96, "intest in");
		check(padOut, 8'hA5, "intest out");
	endtask
	task automatic t_reset;
		load_ir(4'hF);
		i_probe.step(7'h40, 1'h0, q);
		i_probe.step(7'h00, 1'h0, q);
		check(irCurrent, 4'hE, "logic reset");
		load_ir(4'hF);
		trst_n <= 1'h0;
		repeat (6) @(posedge clk);
		check(irCurrent, 4'hE, "test reset");
		trst_n <= 1'h1;
		repeat (6) @(posedge clk);
		i_probe.scan(1'h0, 32, 64'h0, dout);
		check(dout[31:0], IDV | 32'h1, "identity again");
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		repeat (6) @(posedge clk);
		t_ident();
		t_bypass();
		t_dap();
		t_bsr();
		t_reset();
		end_of_test();
	end
	initial begin
		#1000000;
		err_count++;
		end_of_test();
	end
endmodule
